// ===== design/dynamics_compressor_expander.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dynamics_compressor_expander
(
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    // Register port
    input  wire logic [dyn_pkg::AW-1:0] i_addr,
    input  wire logic [dyn_pkg::DW-1:0] i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [dyn_pkg::DW-1:0] o_rdata,
    // Audio stream
    input  wire dyn_pkg::stream_t       i_in,
    output dyn_pkg::sample_t            o_out
);
    import dyn_pkg::*;

    cfg_t                 cfg;
    cfg_t                 next_cfg;
    logic [DW-1:0]        next_rdata;
    logic                 det_valid;
    logic signed [SW-1:0] det_audio;
    logic signed [12:0]   lvl;
    logic signed [12:0]   thr16;
    logic signed [13:0]   lvl_x;
    logic signed [13:0]   thr_x;
    logic [7:0]           kh;
    logic [13:0]          kd;
    logic [25:0]          raw;
    logic [11:0]          target;
    logic [35:0]          acc;
    logic [35:0]          next_acc;
    logic [35:0]          tgt_acc;
    logic [11:0]          gr;
    logic [15:0]          fs_khz;
    logic [4:0]           s_att;
    logic [4:0]           s_rel;
    logic                 v2;
    logic signed [SW-1:0] a2;
    logic signed [12:0]   g;
    logic signed [28:0]   g2full;
    logic signed [9:0]    g2;
    logic signed [5:0]    oct;
    logic [4:0]           sh;
    logic [15:0]          lin;
    logic signed [40:0]   prod;
    logic signed [40:0]   sc;
    sample_t              next_out;

    // Share of the reduction kept, 1 - 1/ratio in Q8
    function automatic logic [8:0] comp_factor(input logic [3:0] r);
        case (r)
            4'h0:    return 9'h000;
            4'h1:    return 9'h017;
            4'h2:    return 9'h03B;
            4'h3:    return 9'h055;
            4'h4:    return 9'h069;
            4'h5:    return 9'h080;
            4'h6:    return 9'h09A;
            4'h7:    return 9'h0AB;
            4'h8:    return 9'h0B7;
            4'h9:    return 9'h0C0;
            4'hA:    return 9'h0CD;
            4'hB:    return 9'h0D5;
            4'hC:    return 9'h0E0;
            4'hD:    return 9'h0E6;
            4'hE:    return 9'h0F3;
            default: return 9'h100;
        endcase
    endfunction

    // Ratio minus one in Q4; infinity saturates the reduction
    function automatic logic [11:0] exp_factor(input logic [3:0] r);
        case (r)
            4'h0:    return 12'h000;
            4'h1:    return 12'h002;
            4'h2:    return 12'h005;
            4'h3:    return 12'h008;
            4'h4:    return 12'h00B;
            4'h5:    return 12'h010;
            4'h6:    return 12'h018;
            4'h7:    return 12'h020;
            4'h8:    return 12'h028;
            4'h9:    return 12'h030;
            4'hA:    return 12'h040;
            4'hB:    return 12'h050;
            4'hC:    return 12'h070;
            4'hD:    return 12'h090;
            4'hE:    return 12'h130;
            default: return 12'hFFF;
        endcase
    endfunction

    // Soft knee: half slope across the knee keeps the curve continuous
    function automatic logic [13:0] knee_map(input logic signed [13:0] e,
                                             input logic [7:0] w);
        logic signed [13:0] k;
        k = signed'({6'h00, w});
        if (e >= k)
            return 14'(e);
        else if (e <= -k)
            return 14'h0000;
        else
            return 14'((e + k) >>> 1);
    endfunction

    function automatic logic [5:0] clamp6(input logic [5:0] v,
                                          input logic [5:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    level_detector u_det
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_in      (i_in),
        .i_key_ext (cfg.key_ext),
        .o_valid   (det_valid),
        .o_audio   (det_audio),
        .o_level   (lvl)
    );

    // Register file
    always_comb
    begin
        next_cfg   = cfg;
        next_rdata = '0;
        if (i_wr)
        begin
            case (i_addr)
                A_CTRL:
                begin
                    next_cfg.mode    = mode_t'(i_wdata[CTRL_MODE]);
                    next_cfg.key_ext = i_wdata[CTRL_KEY];
                    next_cfg.fs      = (i_wdata[CTRL_FS+:2] == 2'h3) ?
                                       fs_32k : fs_t'(i_wdata[CTRL_FS+:2]);
                end
                A_THRESH:  next_cfg.thresh = clamp6(i_wdata[5:0],
                                                    THR_MAX);
                A_RATIO:   next_cfg.ratio = i_wdata[3:0];
                A_ATTACK:  next_cfg.attack = (i_wdata[6:0] > ATK_MAX) ?
                                             ATK_MAX : i_wdata[6:0];
                A_RELEASE: next_cfg.rel_idx = (i_wdata[7:0] > REL_MAX) ?
                                              REL_MAX : i_wdata[7:0];
                A_OUTGAIN: next_cfg.outgain = clamp6(i_wdata[5:0],
                                                     OUTG_MAX);
                A_KNEE:    next_cfg.knee = (i_wdata[2:0] > KNEE_MAX) ?
                                           KNEE_MAX : i_wdata[2:0];
                default:   next_cfg = cfg;
            endcase
        end
        if (i_rd)
        begin
            case (i_addr)
                A_CTRL:    next_rdata = DW'({cfg.fs, cfg.key_ext, cfg.mode});
                A_THRESH:  next_rdata = DW'(cfg.thresh);
                A_RATIO:   next_rdata = DW'(cfg.ratio);
                A_ATTACK:  next_rdata = DW'(cfg.attack);
                A_RELEASE: next_rdata = DW'(cfg.rel_idx);
                A_OUTGAIN: next_rdata = DW'(cfg.outgain);
                A_KNEE:    next_rdata = DW'(cfg.knee);
                default:   next_rdata = DW'(gr);
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            cfg     <= '{compressor_program, 1'b0, fs_48k, RST_THRESH,
                         RST_RATIO, RST_ATTACK, RST_RELEASE, RST_OUTGAIN,
                         RST_KNEE};
            o_rdata <= '0;
        end
        else
        begin
            cfg     <= next_cfg;
            o_rdata <= next_rdata;
        end
    end

    // Static curve and per-sample gain smoothing
    always_comb
    begin
        thr16 = signed'({3'b000, cfg.thresh, 4'h0}) - THR_BIAS;
        lvl_x = {lvl[12], lvl};
        thr_x = {thr16[12], thr16};
        kh    = 8'(cfg.knee * KNEE_HALF);
        if (cfg.mode == compressor_program)
        begin
            kd  = knee_map(lvl_x - thr_x, kh);
            raw = (26'(kd) * 26'(comp_factor(cfg.ratio))) >> 8;
        end
        else
        begin
            kd  = knee_map(thr_x - lvl_x, kh);
            raw = (26'(kd) * 26'(exp_factor(cfg.ratio))) >> 4;
        end
        target  = (raw > 26'(GR_MAX)) ? GR_MAX : raw[11:0];
        tgt_acc = {target, {GR_FRAC{1'b0}}};
        case (cfg.fs)
            fs_44k:  fs_khz = FS_KHZ_44;
            fs_32k:  fs_khz = FS_KHZ_32;
            default: fs_khz = FS_KHZ_48;
        endcase
        // Attack in ms follows the rate; release is fixed in samples,
        // so its time in seconds scales with the rate by itself
        s_att = msb_pos(24'(16'(cfg.attack) * fs_khz));
        s_rel = REL_BASE + 5'((16'(cfg.rel_idx) * REL_SLOPE) >> 8);
        next_acc = acc;
        if (det_valid)
        begin
            if (tgt_acc > acc)
                next_acc = (cfg.attack == '0) ? tgt_acc :
                           acc + ((tgt_acc - acc) >> s_att);
            else
                next_acc = acc - ((acc - tgt_acc) >> s_rel);
        end
    end

    // Gain state lives per instance, one per path
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            acc <= '0;
            v2  <= 1'b0;
            a2  <= '0;
        end
        else
        begin
            acc <= next_acc;
            v2  <= det_valid;
            a2  <= det_valid ? det_audio : a2;
        end
    end

    assign gr = acc[35:GR_FRAC];

    // dB gain to linear Q12, then apply
    always_comb
    begin
        g      = signed'(13'({cfg.outgain, 3'b000})) -
                 signed'({1'b0, gr});
        g2full = 29'(g) * 29'(OCT_PER_DB);
        // Round to the nearest sixteenth octave; truncation loses up to 4 % gain
        g2     = g2full[25:16] + 10'(g2full[15]);
        oct    = g2[9:4];
        sh     = 5'(6'sd3 - oct);
        lin    = 16'({1'b1, g2[3:0]}) << 11 >> sh;
        prod   = 41'(a2) * 41'(signed'({1'b0, lin}));
        sc     = prod >>> 12;
        next_out.valid = v2;
        if (!v2)
            next_out.audio = o_out.audio;
        else if (sc > 41'sh7FFFFF)
            next_out.audio = {1'b0, {(SW-1){1'b1}}};
        else if (sc < -41'sh800000)
            next_out.audio = {1'b1, {(SW-1){1'b0}}};
        else
            next_out.audio = sc[SW-1:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_out <= '0;
        else
            o_out <= next_out;
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_thr_wr;
        i_wr && i_addr == A_THRESH;
    endsequence
    sequence s_thr_rd;
        i_rd && i_addr == A_THRESH;
    endsequence

    property p_latency;
        i_in.valid |-> ##3 o_out.valid;
    endproperty
    a_latency: assert property (p_latency)
        else $error("output sample not three cycles after input");

    property p_comp_pass;
        det_valid && cfg.mode == compressor_program && cfg.knee == '0
            && lvl < thr16 |-> target == '0;
    endproperty
    a_comp_pass: assert property (p_comp_pass)
        else $error("compressor reduced gain below threshold");

    property p_comp_reduce;
        det_valid && cfg.mode == compressor_program && cfg.ratio != '0
            && lvl >= thr16 + 13'sd16 |-> target != '0;
    endproperty
    a_comp_reduce: assert property (p_comp_reduce)
        else $error("compressor left gain unchanged above threshold");

    property p_limit;
        det_valid && cfg.mode == compressor_program && cfg.knee == '0
            && cfg.ratio == RATIO_INF && lvl >= thr16
            |-> target == 12'(lvl - thr16);
    endproperty
    a_limit: assert property (p_limit)
        else $error("infinite ratio did not hold output at threshold");

    property p_exp_pass;
        det_valid && cfg.mode == expander_program && cfg.knee == '0
            && lvl > thr16 |-> target == '0;
    endproperty
    a_exp_pass: assert property (p_exp_pass)
        else $error("expander attenuated above threshold");

    property p_exp_atten;
        det_valid && cfg.mode == expander_program && cfg.ratio != '0
            && lvl + 13'sd16 <= thr16 |-> target != '0;
    endproperty
    a_exp_atten: assert property (p_exp_atten)
        else $error("expander did not attenuate below threshold");

    property p_attack_now;
        det_valid && cfg.attack == '0 && target > gr
            |=> gr == $past(target);
    endproperty
    a_attack_now: assert property (p_attack_now)
        else $error("zero attack did not apply reduction at once");

    property p_release_down;
        det_valid && target < gr |=> gr <= $past(gr) && gr >= $past(target);
    endproperty
    a_release_down: assert property (p_release_down)
        else $error("release moved gain the wrong way");

    property p_thr_clamp;
        s_thr_wr ##1 s_thr_rd |=> o_rdata <= DW'(THR_MAX);
    endproperty
    a_thr_clamp: assert property (p_thr_clamp)
        else $error("threshold index above 0 dB");
endmodule
`default_nettype wire

// ===== design/dyn_pkg.sv
package dyn_pkg;
    // Widths
    localparam int SW = 24;
    localparam int DW = 16;
    localparam int AW = 3;

    // Register offsets
    localparam logic [2:0] A_CTRL    = 3'h0;
    localparam logic [2:0] A_THRESH  = 3'h1;
    localparam logic [2:0] A_RATIO   = 3'h2;
    localparam logic [2:0] A_ATTACK  = 3'h3;
    localparam logic [2:0] A_RELEASE = 3'h4;
    localparam logic [2:0] A_OUTGAIN = 3'h5;
    localparam logic [2:0] A_KNEE    = 3'h6;
    localparam logic [2:0] A_STATUS  = 3'h7;

    // Control field positions
    localparam int CTRL_MODE = 0;
    localparam int CTRL_KEY  = 1;
    localparam int CTRL_FS   = 2;

    // Setting limits (index form)
    localparam logic [5:0] THR_MAX   = 6'h36;
    localparam logic [3:0] RATIO_INF = 4'hF;
    localparam logic [6:0] ATK_MAX   = 7'h78;
    localparam logic [7:0] REL_MAX   = 8'h9F;
    localparam logic [5:0] OUTG_MAX  = 6'h24;
    localparam logic [2:0] KNEE_MAX  = 3'h5;

    // Values after reset
    localparam logic [5:0] RST_THRESH  = 6'h24;
    localparam logic [3:0] RST_RATIO   = 4'h5;
    localparam logic [6:0] RST_ATTACK  = 7'h0A;
    localparam logic [7:0] RST_RELEASE = 8'h40;
    localparam logic [5:0] RST_OUTGAIN = 6'h00;
    localparam logic [2:0] RST_KNEE    = 3'h0;

    // Level arithmetic, dB scaled by 16
    localparam logic signed [12:0] THR_BIAS   = 13'sh0360;
    localparam logic        [7:0]  KNEE_HALF  = 8'h30;
    localparam logic        [11:0] GR_MAX     = 12'h600;
    localparam logic signed [9:0]  LOG_FS     = 10'sh170;
    localparam logic signed [11:0] DB_PER_OCT = 12'sh605;
    localparam logic signed [15:0] OCT_PER_DB = 16'sh2A85;
    localparam logic signed [12:0] LVL_FLOOR  = -13'sh0960;
    localparam int                 GR_FRAC    = 24;

    // Smoothing time constants, in samples (log2), and sample rates in kHz
    localparam logic [4:0]  REL_BASE  = 5'h08;
    localparam logic [15:0] REL_SLOPE = 16'h0015;
    localparam logic [15:0] FS_KHZ_48 = 16'h0030;
    localparam logic [15:0] FS_KHZ_44 = 16'h002C;
    localparam logic [15:0] FS_KHZ_32 = 16'h0020;

    typedef enum logic {
        compressor_program = 1'b0,
        expander_program   = 1'b1
    } mode_t;

    typedef enum logic [1:0] {
        fs_48k = 2'h0,
        fs_44k = 2'h1,
        fs_32k = 2'h2
    } fs_t;

    typedef struct packed {
        mode_t       mode;
        logic        key_ext;
        fs_t         fs;
        logic [5:0]  thresh;
        logic [3:0]  ratio;
        logic [6:0]  attack;
        logic [7:0]  rel_idx;
        logic [5:0]  outgain;
        logic [2:0]  knee;
    } cfg_t;

    typedef struct packed {
        logic                 valid;
        logic signed [SW-1:0] audio;
        logic signed [SW-1:0] key;
    } stream_t;

    typedef struct packed {
        logic                 valid;
        logic signed [SW-1:0] audio;
    } sample_t;

    function automatic logic [4:0] msb_pos(input logic [23:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 24; i++)
        begin
            if (v[i])
                p = 5'(i);
        end
        return p;
    endfunction
endpackage

// ===== design/level_detector.sv
`timescale 1ns/1ps
`default_nettype none
module level_detector
(
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    // Stream in and key choice
    input  wire dyn_pkg::stream_t       i_in,
    input  wire logic                   i_key_ext,
    // Delayed audio and key level
    output logic                        o_valid,
    output logic signed [dyn_pkg::SW-1:0] o_audio,
    output logic signed [12:0]          o_level
);
    import dyn_pkg::*;

    logic signed [SW-1:0] src;
    logic        [SW-1:0] mag;
    logic        [4:0]    pos;
    logic        [27:0]   norm;
    logic signed [9:0]    rel2;
    logic signed [21:0]   prod;
    logic signed [12:0]   next_level;

    always_comb
    begin
        src = i_key_ext ? i_in.key : i_in.audio;
        if (src == {1'b1, {(SW-1){1'b0}}})
            mag = {1'b0, {(SW-1){1'b1}}};
        else if (src[SW-1])
            mag = SW'(-src);
        else
            mag = SW'(src);
        pos  = msb_pos(mag);
        // Four bits under the leading one give a linear log2 fraction
        norm = {mag, 4'h0} >> pos;
        rel2 = signed'({1'b0, pos, norm[3:0]}) - LOG_FS;
        prod = 22'(rel2) * 22'(DB_PER_OCT);
        if (mag == '0)
            next_level = LVL_FLOOR;
        else
            next_level = prod[20:8];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_audio <= '0;
            o_level <= LVL_FLOOR;
        end
        else
        begin
            o_valid <= i_in.valid;
            o_audio <= i_in.valid ? i_in.audio : o_audio;
            o_level <= i_in.valid ? next_level : o_level;
        end
    end
endmodule
`default_nettype wire

// ===== verif/audio_path_model.sv
`timescale 1ns/1ps
`default_nettype none
module audio_path_model
(
    // Clock
    input  wire logic                   i_ref_clk,
    // Stream into and out of the block
    output dyn_pkg::stream_t            o_in,
    input  wire dyn_pkg::sample_t       i_out,
    // What the path saw
    output logic signed [dyn_pkg::SW-1:0] o_got,
    output int                          o_lat_err
);
    import dyn_pkg::*;

    logic [2:0] pend;
    logic       armed;

    initial
    begin
        o_in = '0;
        o_got = '0;
        o_lat_err = 0;
        pend = '0;
        armed = 1'b0;
    end

    // Unqualified lines carry the inverse, so a stale sample never passes
    task automatic send(input logic signed [SW-1:0] a,
                        input logic signed [SW-1:0] k);
        @(posedge i_ref_clk);
        o_in <= '{1'b1, a, k};
        @(posedge i_ref_clk);
        o_in <= '{1'b0, ~a, ~k};
    endtask

    // Output must follow each taken sample by a fixed three cycles
    always @(posedge i_ref_clk)
    begin
        // The first edge only loads the block's reset value
        armed <= 1'b1;
        pend <= {pend[1:0], o_in.valid};
        if (armed && i_out.valid !== pend[2])
            o_lat_err <= o_lat_err + 1;
        if (i_out.valid === 1'b1)
            o_got <= i_out.audio;
    end
endmodule
`default_nettype wire

// ===== verif/tb_dynamics_compressor_expander.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module tb_dynamics_compressor_expander;
    import dyn_pkg::*;

    localparam real LVL_HALF = -6.0206;

    logic                 ref_clk;
    logic                 rst;
    logic [AW-1:0]        addr;
    logic [DW-1:0]        wdata;
    logic                 wr;
    logic                 rd;
    logic [DW-1:0]        rdata;
    stream_t              in_s;
    sample_t              out_s;
    logic signed [SW-1:0] got;
    logic signed [SW-1:0] smp;
    logic [DW-1:0]        v;
    int                   lat_err;
    int                   n_fail;
    int                   checks_done;
    int                   seed;
    real                  ratio_tab [16];

    dynamics_compressor_expander i_dynamics_compressor_expander
    (
        .i_ref_clk (ref_clk),
        .i_rst     (rst),
        .i_addr    (addr),
        .i_wdata   (wdata),
        .i_wr      (wr),
        .i_rd      (rd),
        .o_rdata   (rdata),
        .i_in      (in_s),
        .o_out     (out_s)
    );

    audio_path_model i_audio_path_model
    (
        .i_ref_clk (ref_clk),
        .o_in      (in_s),
        .i_out     (out_s),
        .o_got     (got),
        .o_lat_err (lat_err)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic results();
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
        logic [DW-1:0] d;
        rd_reg(a, d);
        `CHECK(d, e)
    endtask

    // Reset, then the settings every scenario starts from
    task automatic setup(input logic [DW-1:0] ctrl, input logic [DW-1:0] thr,
                         input logic [DW-1:0] atk);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        wr_reg(A_CTRL, ctrl);
        wr_reg(A_THRESH, thr);
        wr_reg(A_RATIO, 16'h000F);
        wr_reg(A_ATTACK, atk);
    endtask

    task automatic play(input logic signed [SW-1:0] a,
                        input logic signed [SW-1:0] k, input int n);
        repeat (n) i_audio_path_model.send(a, k);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic near(input logic signed [31:0] g,
                                  input real e, input real tol);
        real d;
        if ($isunknown(g))
            return 1'b0;
        d = g - e;
        if (d < 0.0)
            d = -d;
        return d <= tol;
    endfunction

    // Expected gain reduction in dB scaled by 16, capped at 96 dB
    function automatic real gr_exp(input logic m, input real lvl,
                                   input real thr, input int ri);
        real g;
        if (m == 1'b0)
            g = (lvl >= thr) ? (lvl - thr) * (1.0 - 1.0 / ratio_tab[ri]) : 0.0;
        else
            g = (lvl <= thr) ? (thr - lvl) * (ratio_tab[ri] - 1.0) : 0.0;
        if (g > 96.0)
            g = 96.0;
        return g * 16.0;
    endfunction

    initial
    begin
        #400000;
        n_fail++;
        results();
    end

    initial
    begin
        seed = 32'h32127F34;
        n_fail = 0;
        checks_done = 0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        rst = 1'b1;
        ratio_tab = '{1.0, 1.1, 1.3, 1.5, 1.7, 2.0, 2.5, 3.0, 3.5, 4.0,
                      5.0, 6.0, 8.0, 10.0, 20.0, 1.0e9};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        chk_reg(A_CTRL, 16'h0000);
        chk_reg(A_THRESH, {10'h000, RST_THRESH});
        chk_reg(A_RATIO, {12'h000, RST_RATIO});
        chk_reg(A_ATTACK, {9'h000, RST_ATTACK});
        chk_reg(A_RELEASE, {8'h00, RST_RELEASE});
        chk_reg(A_OUTGAIN, 16'h0000);
        chk_reg(A_KNEE, 16'h0000);
        wr_reg(A_STATUS, 16'hFFFF);
        chk_reg(A_STATUS, 16'h0000);
        @(posedge ref_clk);
        #1 `CHECK(rdata, 16'h0000)
        // Settings beyond the top of each range clamp to the last step
        // Write then read with no gap: the read sees the clamped value
        @(posedge ref_clk);
        addr <= A_THRESH;
        wdata <= 16'h003F;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 `CHECK(rdata, 16'h0036)
        wr_reg(A_ATTACK, 16'h007F);
        chk_reg(A_ATTACK, 16'h0078);
        wr_reg(A_RELEASE, 16'h00FF);
        chk_reg(A_RELEASE, 16'h009F);
        wr_reg(A_OUTGAIN, 16'h003F);
        chk_reg(A_OUTGAIN, 16'h0024);
        wr_reg(A_KNEE, 16'h0007);
        chk_reg(A_KNEE, 16'h0005);
        repeat (20)
        begin
            v = 16'($unsigned($random(seed)) % 55);
            wr_reg(A_THRESH, v);
            chk_reg(A_THRESH, v);
            v = 16'($unsigned($random(seed)) % 160);
            wr_reg(A_RELEASE, v);
            chk_reg(A_RELEASE, v);
        end
        // External key silent: audio passes untouched whatever its level
        setup(16'h0002, 16'h0000, 16'h0000);
        repeat (10)
        begin
            smp = SW'($random(seed));
            play(smp, 24'sh000000, 1);
            `CHECK(got, smp)
        end
        chk_reg(A_STATUS, 16'h0000);
        wr_reg(A_OUTGAIN, 16'h000C);
        play(24'sh010000, 24'sh000000, 1);
        `CHECK(near(got, 65536.0 * 10.0 ** 0.3, 1310.0), 1'b1)
        wr_reg(A_OUTGAIN, 16'h0000);
        wr_reg(A_CTRL, 16'h0000);
        play(24'sh400000, 24'sh000000, 3);
        rd_reg(A_STATUS, v);
        `CHECK(near(v, gr_exp(1'b0, LVL_HALF, -54.0, 15), 32.0), 1'b1)
        `CHECK(near(got, 4194304.0 * 10.0 ** (-2.4), 1700.0), 1'b1)
        play(24'sh000000, 24'sh000000, 1);
        rd_reg(A_STATUS, v);
        `CHECK(near(v, 768.0, 64.0), 1'b1)
        // Slow attack barely moves; hard knee just under threshold is idle
        setup(16'h0000, 16'h0000, 16'h0078);
        play(24'sh400000, 24'sh400000, 1);
        rd_reg(A_STATUS, v);
        `CHECK(near(v, 0.0, 384.0), 1'b1)
        setup(16'h0000, 16'h0030, 16'h0000);
        play(24'sh400000, 24'sh400000, 2);
        rd_reg(A_STATUS, v);
        `CHECK(near(v, 0.0, 16.0), 1'b1)
        wr_reg(A_KNEE, 16'h0005);
        play(24'sh400000, 24'sh400000, 2);
        rd_reg(A_STATUS, v);
        `CHECK(v > 16'h0010, 1'b1)
        setup(16'h0000, 16'h0000, 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            wr_reg(A_RATIO, 16'(i));
            play(24'sh400000, 24'sh400000, 3);
            rd_reg(A_STATUS, v);
            `CHECK(near(v, gr_exp(1'b0, LVL_HALF, -54.0, i), 32.0), 1'b1)
        end
        // Expander: key above threshold passes, below it ratios expand
        setup(16'h0003, 16'h0000, 16'h0000);
        play(24'sh123456, 24'sh400000, 2);
        `CHECK(got, 24'sh123456)
        chk_reg(A_STATUS, 16'h0000);
        wr_reg(A_THRESH, 16'h0036);
        for (int i = 0; i < 16; i++)
        begin
            wr_reg(A_RATIO, 16'(i));
            play(24'sh123456, 24'sh400000, 3);
            rd_reg(A_STATUS, v);
            `CHECK(near(v, gr_exp(1'b1, LVL_HALF, 0.0, i), 32.0), 1'b1)
        end
        `CHECK(lat_err, 0)
        results();
    end
endmodule
`default_nettype wire
